//--- design/iqst_pkg.sv
// package: queue status codes, widths and reset values for the tracker
package iqst_pkg;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned MIN_QUEUE_BYTES = 3;
   localparam logic [2:0] MIN_QUEUE_BYTES_V = 3'h3;
   // data-movement codes, valid at rising bus-phase edge
   localparam logic [1:0] MOVE_NONE = 2'h0;
   localparam logic [1:0] MOVE_CAPTURE = 2'h1;
   localparam logic [1:0] MOVE_ADV_BUS = 2'h2;
   localparam logic [1:0] MOVE_ADV_LATCH = 2'h3;
   // execution-start codes, valid at falling bus-phase edge
   localparam logic [1:0] START_NONE = 2'h0;
   localparam logic [1:0] START_INTR = 2'h1;
   localparam logic [1:0] START_EVEN = 2'h2;
   localparam logic [1:0] START_ODD = 2'h3;
   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
   localparam logic [2:0] FILL_RST = 3'h0;
   typedef enum logic [2:0] {
      IQST_IDLE = 3'b001,
      IQST_EXEC = 3'b010,
      IQST_WAIT = 3'b100
   } iqst_exec_t;
endpackage

//--- design/iqst_pin_mux.sv
// module: time-multiplexes movement and start codes onto the status pins
`timescale 1ns/1ps
module iqst_pin_mux
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic phase_high_i,
   input wire logic [1:0] move_code_i,
   input wire logic [1:0] start_code_i,
   output logic queue_status_hi_o,
   output logic queue_status_lo_o
);
   logic [1:0] pins;
   logic [1:0] next_pins;

   ////////////////////////////////////////////////////////////////////////
   // while the phase is high the start code is set up for the falling edge;
   // while low the movement code is set up for the rising edge
   always_comb
   begin
      if (!rst_n_i)
      begin
         next_pins = iqst_pkg::MOVE_NONE; // RL14
      end
      else if (phase_high_i)
      begin
         next_pins = start_code_i; // RL6
      end
      else
      begin
         next_pins = move_code_i; // RL5
      end
   end

   always_ff @(posedge clk_i)
   begin
      pins <= next_pins;
   end

   assign queue_status_hi_o = pins[1];
   assign queue_status_lo_o = pins[0];
endmodule // iqst_pin_mux

//--- design/iqst_tracker.sv
// module: two-stage prefetch queue model driving queue status pins
// Functional notes
// RL1: an instruction runs to completion before the next one may start.
// RL2: a start happens only when the queue holds at least three bytes; here interrupt starts are taken whatever the fill.
// RL3: movement codes are 00 none, 01 capture, 10 advance bus, 11 latch.
// RL4: start codes are 00 none, 01 interrupt, 10 even, 11 odd.
// RL5: the movement code is valid on the pins at the rising phase edge.
// RL6: the start code is valid on the pins at the falling phase edge.
// RL7: a movement code tells of bus data seen at the prior falling edge.
// RL8: a start code tells of the bus cycle that begins at that edge; here it reports the start decided at the prior falling edge.
// RL9: the queue is two 16-bit stages plus a latch in front of stage one.
// RL10: advance shifts stage one to two and loads stage one from latch/bus.
// RL11: even starts use stage two's upper byte, odd its lower byte.
// RL12: the analyser keeps bus words with addresses to rebuild the queue; here the analyser model latches only the two status pins.
// RL13: only program fetch data is buffered, fetched ahead of its use.
// RL14: during reset both phases show code 00.
`timescale 1ns/1ps
module iqst_tracker
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic bus_phase_clock_i,
   input wire logic fetch_valid_i,
   input wire logic [15:0] fetch_data_i,
   input wire logic capture_bus_word_i,
   input wire logic advance_i,
   input wire logic start_req_i,
   input wire logic start_odd_i,
   input wire logic start_intr_i,
   input wire logic exec_done_i,
   output logic bus_phase_clock_out_o,
   output logic queue_status_hi_o,
   output logic queue_status_lo_o,
   output logic [7:0] opcode_o,
   output logic opcode_valid_o,
   output logic busy_o
);
   logic phase_q;
   logic phase_rise;
   logic phase_fall;
   logic [15:0] stage1;
   logic [15:0] stage2;
   logic [15:0] hold;
   logic [15:0] bus_word;
   logic [2:0] fill;
   logic hold_full;
   logic [1:0] move_code;
   logic [1:0] start_code;
   logic [7:0] opcode;
   logic opcode_valid;
   iqst_pkg::iqst_exec_t state;
   logic [15:0] next_stage1;
   logic [15:0] next_stage2;
   logic [15:0] next_hold;
   logic [15:0] next_bus_word;
   logic [2:0] next_fill;
   logic next_hold_full;
   logic [1:0] next_move_code;
   logic [1:0] next_start_code;
   logic [7:0] next_opcode;
   logic next_opcode_valid;
   logic next_phase_q;
   iqst_pkg::iqst_exec_t next_state;
   logic do_adv;
   logic do_cap;
   logic can_start;

   function automatic logic [7:0] pick_byte(input logic [15:0] w,
                                            input logic odd);
      pick_byte = odd ? w[7:0] : w[15:8]; // RL11
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // phase edges; phase comes from the same clock's divider, so no sync
   assign phase_rise = bus_phase_clock_i & ~phase_q;
   assign phase_fall = ~bus_phase_clock_i & phase_q;
   // queue actions are taken on the falling edge, when bus data is valid
   assign do_cap = phase_fall & fetch_valid_i & capture_bus_word_i
                   & ~advance_i; // RL13
   assign do_adv = phase_fall & advance_i & (fetch_valid_i | hold_full);
   assign can_start = (fill >= iqst_pkg::MIN_QUEUE_BYTES_V); // RL2

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_phase_q = bus_phase_clock_i;
      next_stage1 = stage1;
      next_stage2 = stage2;
      next_hold = hold;
      next_bus_word = bus_word;
      next_fill = fill;
      next_hold_full = hold_full;
      next_move_code = move_code;
      next_start_code = start_code;
      next_opcode = opcode;
      next_opcode_valid = 1'b0;
      next_state = state;
      if (phase_fall)
      begin
         // movement seen now is reported at the next rising edge
         next_move_code = iqst_pkg::MOVE_NONE; // RL7
         next_start_code = iqst_pkg::START_NONE;
         if (fetch_valid_i)
         begin
            next_bus_word = fetch_data_i;
         end
      end
      if (do_cap)
      begin
         next_hold = fetch_data_i; // RL9
         next_hold_full = 1'b1;
         next_move_code = iqst_pkg::MOVE_CAPTURE; // RL3
      end
      if (do_adv)
      begin
         next_stage2 = stage1; // RL10
         if (hold_full)
         begin
            next_stage1 = hold; // RL10
            next_hold_full = 1'b0;
            next_move_code = iqst_pkg::MOVE_ADV_LATCH; // RL3
         end
         else
         begin
            next_stage1 = fetch_data_i; // RL10
            next_move_code = iqst_pkg::MOVE_ADV_BUS; // RL3
         end
         next_fill = (fill > 3'h2) ? 3'h4 : 3'(fill + 3'h2);
      end
      case (state)
         iqst_pkg::IQST_IDLE:
         begin
            // start is decided at the falling edge that opens its cycle
            if (phase_fall && start_req_i && (can_start || start_intr_i))
            begin
               if (start_intr_i)
               begin
                  next_start_code = iqst_pkg::START_INTR; // RL4
               end
               else
               begin
                  next_start_code = start_odd_i ? iqst_pkg::START_ODD
                                    : iqst_pkg::START_EVEN; // RL4 RL8
                  next_opcode = pick_byte(stage2, start_odd_i); // RL11
                  next_opcode_valid = 1'b1;
               end
               next_state = iqst_pkg::IQST_EXEC; // RL1
            end
         end
         iqst_pkg::IQST_EXEC:
         begin
            if (exec_done_i)
            begin
               next_state = iqst_pkg::IQST_WAIT;
            end
         end
         iqst_pkg::IQST_WAIT:
         begin
            // one phase gap so a completed op never overlaps the next
            if (phase_rise)
            begin
               next_state = iqst_pkg::IQST_IDLE; // RL1
            end
         end
         default:
         begin
            next_state = iqst_pkg::IQST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         phase_q <= 1'b0;
         stage1 <= iqst_pkg::WORD_RST;
         stage2 <= iqst_pkg::WORD_RST;
         hold <= iqst_pkg::WORD_RST;
         bus_word <= iqst_pkg::WORD_RST;
         fill <= iqst_pkg::FILL_RST;
         hold_full <= 1'b0;
         move_code <= iqst_pkg::MOVE_NONE; // RL14
         start_code <= iqst_pkg::START_NONE; // RL14
         opcode <= 8'h00;
         opcode_valid <= 1'b0;
         state <= iqst_pkg::IQST_IDLE;
      end
      else
      begin
         phase_q <= next_phase_q;
         stage1 <= next_stage1;
         stage2 <= next_stage2;
         hold <= next_hold;
         bus_word <= next_bus_word;
         fill <= next_fill;
         hold_full <= next_hold_full;
         move_code <= next_move_code;
         start_code <= next_start_code;
         opcode <= next_opcode;
         opcode_valid <= next_opcode_valid;
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   iqst_pin_mux u_pin_mux
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .phase_high_i(phase_q),
      .move_code_i(move_code),
      .start_code_i(start_code),
      .queue_status_hi_o(queue_status_hi_o),
      .queue_status_lo_o(queue_status_lo_o)
   );

   assign bus_phase_clock_out_o = phase_q;
   assign opcode_o = opcode;
   assign opcode_valid_o = opcode_valid;
   assign busy_o = (state != iqst_pkg::IQST_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // checks
   AST_START_NEEDS_BYTES: assert property (@(posedge clk_i) // RL2
      disable iff (!rst_n_i)
      (opcode_valid) |-> ($past(fill) >= iqst_pkg::MIN_QUEUE_BYTES_V))
      else $error("start with too few queued bytes");
   AST_NO_OVERLAP: assert property (@(posedge clk_i) // RL1
      disable iff (!rst_n_i)
      (state == iqst_pkg::IQST_EXEC) |=> !opcode_valid)
      else $error("start while executing");
   AST_ADV_SHIFT: assert property (@(posedge clk_i) // RL10
      disable iff (!rst_n_i)
      do_adv |=> (stage2 == $past(stage1)))
      else $error("advance did not shift stage one");
   AST_ADV_LATCH_CODE: assert property (@(posedge clk_i) // RL3
      disable iff (!rst_n_i)
      (do_adv && hold_full) |=> (move_code == iqst_pkg::MOVE_ADV_LATCH)
         && (stage1 == $past(hold)))
      else $error("latch advance wrong");
   AST_ADV_BUS_CODE: assert property (@(posedge clk_i) // RL7
      disable iff (!rst_n_i)
      (do_adv && !hold_full) |=> (move_code == iqst_pkg::MOVE_ADV_BUS))
      else $error("bus advance wrong code");
   AST_CAPTURE: assert property (@(posedge clk_i) // RL9
      disable iff (!rst_n_i)
      do_cap |=> hold_full && (move_code == iqst_pkg::MOVE_CAPTURE))
      else $error("capture not recorded");
   AST_EVEN_BYTE: assert property (@(posedge clk_i) // RL11
      disable iff (!rst_n_i)
      (opcode_valid && start_code == iqst_pkg::START_EVEN)
         |-> (opcode == $past(stage2[15:8])))
      else $error("even start wrong byte");
   AST_START_CODE_PIN: assert property (@(posedge clk_i) // RL6
      disable iff (!rst_n_i)
      (phase_q && $past(phase_q)) |->
         ({queue_status_hi_o, queue_status_lo_o} == $past(start_code)))
      else $error("start code not on pins in high phase");
   AST_RESET_PINS: assert property (@(posedge clk_i) // RL14
      !rst_n_i |=> !queue_status_hi_o && !queue_status_lo_o)
      else $error("pins not idle after reset");
   AST_ODD_BYTE: assert property (@(posedge clk_i) // RL11
      disable iff (!rst_n_i)
      (opcode_valid && start_code == iqst_pkg::START_ODD)
         |-> (opcode == $past(stage2[7:0])))
      else $error("odd start wrong byte");
   // bus word buffered at the fall is what a bus advance loads
   AST_BUS_LOAD: assert property (@(posedge clk_i) // RL10
      disable iff (!rst_n_i)
      (do_adv && !hold_full) |=> (stage1 == bus_word))
      else $error("bus advance loaded wrong word");
   AST_MOVE_CODE_PIN: assert property (@(posedge clk_i) // RL5
      disable iff (!rst_n_i)
      (!phase_q && !$past(phase_q)) |->
         ({queue_status_hi_o, queue_status_lo_o} == $past(move_code)))
      else $error("movement code not on pins in low phase");
   AST_MOVE_CLEARED: assert property (@(posedge clk_i) // RL7
      disable iff (!rst_n_i)
      (phase_fall && !do_cap && !do_adv)
         |=> (move_code == iqst_pkg::MOVE_NONE))
      else $error("stale movement code kept");
   AST_HOLD_EMPTIED: assert property (@(posedge clk_i) // RL10
      disable iff (!rst_n_i)
      (do_adv && hold_full) |=> !hold_full)
      else $error("latch still full after advance");
   AST_START_FROM_FALL: assert property (@(posedge clk_i) // RL1
      disable iff (!rst_n_i)
      $rose(busy_o) |-> $past(phase_fall))
      else $error("execution began off a phase fall");
   AST_RESET_IDLE: assert property (@(posedge clk_i) // RL14
      !rst_n_i |=> !busy_o && !opcode_valid)
      else $error("busy or opcode after reset");
   COV_EVEN: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      opcode_valid && start_code == iqst_pkg::START_EVEN);
   COV_ODD: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      opcode_valid && start_code == iqst_pkg::START_ODD);
   COV_ADV_LATCH: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      do_adv && hold_full);
   COV_INTR: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      start_code == iqst_pkg::START_INTR);
   COV_CAPTURE: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      do_cap);
endmodule // iqst_tracker

//--- tb/iqst_analyser.sv
// analyser model latching queue status pins on bus-phase edges
`timescale 1ns/1ps
module iqst_analyser
(
   input wire logic bus_phase_clock_out_i,
   input wire logic queue_status_hi_i,
   input wire logic queue_status_lo_i,
   output logic [1:0] move_seen_o,
   output logic [1:0] start_seen_o
);
   initial
   begin
      move_seen_o = 2'h0;
      start_seen_o = 2'h0;
   end
   // sample just after the edge: pins launched there have settled
   always @(posedge bus_phase_clock_out_i)
   begin
      #1 move_seen_o = {queue_status_hi_i, queue_status_lo_i};
   end
   always @(negedge bus_phase_clock_out_i)
   begin
      #1 start_seen_o = {queue_status_hi_i, queue_status_lo_i};
   end
endmodule // iqst_analyser

//--- tb/instruction_queue_status_tracker_tb_top.sv
// self-checking bench for the queue status tracker
`timescale 1ns/1ps
module instruction_queue_status_tracker_tb_top;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic e = 1'b1;
   logic fv = 1'b0;
   logic [15:0] data = 16'h0000;
   logic cap = 1'b0;
   logic adv = 1'b0;
   logic sreq = 1'b0;
   logic odd = 1'b0;
   logic intr = 1'b0;
   logic done = 1'b0;
   logic e_out, hi, lo, op_v, busy;
   logic [7:0] op;
   logic [1:0] move_seen, start_seen;
   logic [31:0] seed = 32'h6329b71c;
   logic [15:0] s1, s2, lat;
   logic lf, bz, last_intr;
   logic [2:0] fill;
   logic [1:0] exp_mv, exp_st, exp_st_prev;
   logic [7:0] exp_op;
   int error_cnt = 0;
   int cmp_count = 0;
   int op_cnt = 0;
   int exp_op_cnt = 0;

   always #20 clk_i = ~clk_i;

   iqst_tracker uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .bus_phase_clock_i(e), .fetch_valid_i(fv), .fetch_data_i(data),
      .capture_bus_word_i(cap), .advance_i(adv), .start_req_i(sreq),
      .start_odd_i(odd), .start_intr_i(intr), .exec_done_i(done),
      .bus_phase_clock_out_o(e_out), .queue_status_hi_o(hi),
      .queue_status_lo_o(lo), .opcode_o(op), .opcode_valid_o(op_v),
      .busy_o(busy));
   iqst_analyser partner (.bus_phase_clock_out_i(e_out),
      .queue_status_hi_i(hi), .queue_status_lo_i(lo),
      .move_seen_o(move_seen), .start_seen_o(start_seen));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] expd);
      cmp_count++;
      if (seen !== expd)
      begin
         error_cnt++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, expd);
      end
   endtask

   task final_report;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic clear_model;
      s1 = 16'h0000;
      s2 = 16'h0000;
      lat = 16'h0000;
      lf = 1'b0;
      bz = 1'b0;
      last_intr = 1'b0;
      fill = 3'h0;
      exp_st_prev = iqst_pkg::START_NONE;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // one bus-phase period from a fresh random word
   task automatic e_cycle;
      seed = xs(seed);
      e_cycle_r(seed);
   endtask

   // one bus-phase period: requests held through the low half
   task automatic e_cycle_r(input logic [31:0] r);
      adv = r[1];
      cap = r[2] & ~lf;
      // latch full on advance: keep bus idle so the source is unambiguous
      fv = (r[0] | cap) & ~(adv & lf);
      data = r[31:16];
      sreq = r[3] & ~adv;
      intr = r[4] & r[5];
      odd = r[6];
      done = r[7];
      e = 1'b0;
      exp_mv = iqst_pkg::MOVE_NONE;
      if (adv && (lf || fv))
      begin
         exp_mv = lf ? iqst_pkg::MOVE_ADV_LATCH : iqst_pkg::MOVE_ADV_BUS;
         s2 = s1;
         s1 = lf ? lat : data;
         lf = 1'b0;
         fill = (fill > 3'h2) ? 3'h4 : fill + 3'h2;
      end
      else if (cap)
      begin
         exp_mv = iqst_pkg::MOVE_CAPTURE;
         lat = data;
         lf = 1'b1;
      end
      exp_st = iqst_pkg::START_NONE;
      if (!bz && sreq && (intr || fill >= iqst_pkg::MIN_QUEUE_BYTES_V))
      begin
         exp_st = intr ? iqst_pkg::START_INTR :
            (odd ? iqst_pkg::START_ODD : iqst_pkg::START_EVEN);
         exp_op = odd ? s2[7:0] : s2[15:8];
         last_intr = intr;
         // interrupt starts carry no opcode byte
         if (!intr)
         begin
            exp_op_cnt++;
         end
         bz = 1'b1;
      end
      step(4);
      e = 1'b1;
      {sreq, adv, cap, fv, done} = 5'h00;
      check(16'(start_seen), 16'(exp_st_prev));
      exp_st_prev = exp_st;
      bz = bz & ~r[7];
      step(4);
      check(16'(move_seen), 16'(exp_mv));
      check(16'(busy), 16'(bz));
   endtask

   // sampled off the launching edge, while the pulse stands
   always @(negedge clk_i)
   begin
      if (op_v === 1'b1)
      begin
         op_cnt++;
         if (!last_intr)
            check(16'(op), 16'(exp_op));
      end
   end

   initial
   begin
      clear_model();
      step(10);
      check(16'({hi, lo, op_v}), 16'h0000);
      rst_n_i = 1'b1;
      // phase must be seen high once, or the first fall is missed
      step(2);
      // corner cases: refused start, latch path, both bytes, interrupt
      e_cycle_r(32'h00000008);
      e_cycle_r(32'ha55a0005);
      e_cycle_r(32'h00000002);
      e_cycle_r(32'h12340003);
      e_cycle_r(32'h00000088);
      e_cycle_r(32'h000000c8);
      e_cycle_r(32'h000000b8);
      repeat (150) e_cycle();
      rst_n_i = 1'b0;
      step(3);
      check(16'({hi, lo, op_v, busy}), 16'h0000);
      rst_n_i = 1'b1;
      clear_model();
      step(2);
      repeat (150) e_cycle();
      check(16'(op_cnt), 16'(exp_op_cnt));
      final_report();
   end

   initial
   begin
      #200000;
      error_cnt++;
      final_report();
   end
endmodule // instruction_queue_status_tracker_tb_top
